// ==== flash_defs.vh ====
`ifndef FLASH_DEFS_VH
`define FLASH_DEFS_VH

// Instruction codes
`define OP_READ 8'h03
`define OP_FAST_READ 8'h0B
`define OP_DUAL_OUT 8'h3B
`define OP_DUAL_IO 8'hBB
`define OP_PAGE_WRITE 8'h02
`define OP_SECTOR_CLEAR 8'h20
`define OP_BLOCK_CLEAR 8'hD8
`define OP_WRITE_UNLOCK 8'h06

// Dummy clocks after the address
`define DUMMY_FAST 5'h08
`define DUMMY_DUAL_OUT 5'h08
`define DUMMY_DUAL_IO 5'h04

// Address bits consumed per rising edge, last bit index of the address phase
`define ADDR_LAST_SINGLE 5'h17
`define ADDR_LAST_DUAL 5'h16

// Array geometry: 20 address bits, 16 blocks
`define ADDR_W 20
`define BLOCK_MSB 19
`define BLOCK_LSB 16
`define BLOCK_COUNT 5'h10

// Self-timed cycle lengths in core clock cycles
`define PROG_CYCLES_DEF 32'h0000_07D0
`define SECTOR_CYCLES_DEF 32'h0000_1F40
`define BLOCK_CYCLES_DEF 32'h0000_4E20

`endif

// ==== serial_flash_seq.v ====
// Operation
// - plain read: opcode, 24-bit address, data out
// - read address increments after every byte
// - read address wraps to zero at top
// - chip select rise ends any read
// - plain read rejected while cycle busy
// - fast read adds one dummy byte
// - fast read: same increment, wrap, rejection
// - dual-output read drives two bits per clock
// - dual-output read: eight dummy clocks, inputs ignored
// - dual I/O read moves two bits both ways
// - dual I/O read: four dummy clocks
// - page write needs unlock latch; only clears bits
// - page write wraps within its page
// - over 256 bytes, last 256 kept
// - under 256 bytes, others untouched
// - page write needs chip select on boundary
// - timed cycle sets pending, clears unlock latch
// - protected page write ignored
// - sector clear: latch, timed, protection honoured
// - erase needs chip select rise right after the address
// - block clear needs unlock latch
// - block clear timed, clears latch, protection honoured
`timescale 1ns/1ps
`include "flash_defs.vh"

module prog_fifo #(
  parameter WIDTH = 28,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire core_clk,
  input wire rst,
  input wire in_valid,
  input wire [WIDTH-1:0] in_data,
  output wire in_ready,
  output wire out_valid,
  output wire [WIDTH-1:0] out_data,
  input wire out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // prog_fifo

module serial_flash_seq #(
  parameter PROG_CYCLES = `PROG_CYCLES_DEF,
  parameter SECTOR_CYCLES = `SECTOR_CYCLES_DEF,
  parameter BLOCK_CYCLES = `BLOCK_CYCLES_DEF,
  parameter FIFO_DEPTH = 8
) (
  input wire core_clk,
  input wire rst,
  input wire chip_select_n,
  input wire serial_clk,
  input wire serial_inout_pin_in,
  output reg serial_inout_pin_out,
  output reg serial_inout_pin_oe_n,
  input wire serial_out_pin_in,
  output reg serial_out_pin_out,
  output reg serial_out_pin_oe_n,
  input wire [2:0] protect_level_bits,
  input wire status_write_busy,
  output reg write_unlock_latch,
  output reg operation_pending_flag,
  output reg [`ADDR_W-1:0] mem_addr,
  input wire [7:0] mem_rdata,
  output reg prog_valid,
  output reg [`ADDR_W-1:0] prog_addr,
  output reg [7:0] prog_data,
  input wire prog_ready,
  output reg erase_req,
  output reg erase_block,
  output reg [`ADDR_W-1:0] erase_addr
);
  localparam L_CMD = 3'h0;
  localparam L_ADDR = 3'h1;
  localparam L_DUMMY = 3'h2;
  localparam L_DATA = 3'h3;
  localparam L_PROG = 3'h4;
  localparam L_ERASE = 3'h5;
  localparam L_CMDEND = 3'h6;
  localparam L_IGN = 3'h7;
  localparam O_IDLE = 2'h0;
  localparam O_DRAIN = 2'h1;
  localparam O_TIME = 2'h2;

  // Block protected by the level: 0 none, n protects top 2^(n-1) blocks, 5 and up all
  function is_protected;
    input [2:0] lvl;
    input [3:0] blk;
    reg [4:0] n;
    begin
      n = (lvl == 3'h0) ? 5'h00 : (lvl >= 3'h5) ? `BLOCK_COUNT : (5'h01 << (lvl - 3'h1));
      is_protected = (({1'b0, blk} + n) >= `BLOCK_COUNT);
    end
  endfunction

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  reg [3:0] sync1;
  reg [3:0] sync2;
  reg [3:0] sync3;
  reg [3:0] pins;
  reg sclk_q;
  reg cs_q;
  wire cs_f = pins[0];
  wire sclk_f = pins[1];
  wire dio_f = pins[2];
  wire do_f = pins[3];
  wire sclk_rise = sclk_f & ~sclk_q;
  wire sclk_fall = ~sclk_f & sclk_q;
  wire cs_rise = cs_f & ~cs_q;
  integer i;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync1 <= 4'h1;
      sync2 <= 4'h1;
      sync3 <= 4'h1;
      pins <= 4'h1;
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
    end else begin
      sync1 <= {serial_out_pin_in, serial_inout_pin_in, serial_clk, chip_select_n};
      sync2 <= sync1;
      sync3 <= sync2;
      for (i = 0; i < 4; i = i + 1) begin
        if (sync2[i] == sync3[i]) begin
          pins[i] <= sync3[i];
        end
      end
      sclk_q <= sclk_f;
      cs_q <= cs_f;
    end
  end

  // ==========================================================
  // Link instruction decoder
  // ==========================================================
  reg [2:0] lstate;
  reg [4:0] bitn;
  reg [4:0] dummy;
  reg [7:0] cmd;
  reg [`ADDR_W-1:0] addr;
  reg dual_in;
  reg dual_out;
  reg [7:0] shreg;
  reg [7:0] pbyte;
  reg [7:0] col;
  reg have_byte;
  reg [7:0] page_buf [0:255];
  reg [255:0] mask;
  reg go_prog;
  reg go_erase;
  reg set_wul;
  wire busy = operation_pending_flag | status_write_busy;
  wire [7:0] next_cmd = {cmd[6:0], dio_f};
  wire [`ADDR_W-1:0] next_addr = dual_in ? {addr[`ADDR_W-3:0], do_f, dio_f} :
    {addr[`ADDR_W-2:0], dio_f};
  wire [7:0] out_byte = (bitn == 5'h00) ? mem_rdata : shreg;
  wire is_read = (next_cmd == `OP_READ) | (next_cmd == `OP_FAST_READ) |
    (next_cmd == `OP_DUAL_OUT) | (next_cmd == `OP_DUAL_IO);
  wire is_write = (next_cmd == `OP_PAGE_WRITE) | (next_cmd == `OP_SECTOR_CLEAR) |
    (next_cmd == `OP_BLOCK_CLEAR);

  always @(posedge core_clk) begin
    if (!cs_f && sclk_rise && lstate == L_PROG && bitn == 5'h07) begin
      page_buf[col] <= {pbyte[6:0], dio_f};
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lstate <= L_CMD;
      bitn <= 5'h00;
      dummy <= 5'h00;
      cmd <= 8'h00;
      addr <= {`ADDR_W{1'b0}};
      dual_in <= 1'b0;
      dual_out <= 1'b0;
      shreg <= 8'h00;
      pbyte <= 8'h00;
      col <= 8'h00;
      have_byte <= 1'b0;
      mask <= {256{1'b0}};
      go_prog <= 1'b0;
      go_erase <= 1'b0;
      set_wul <= 1'b0;
      mem_addr <= {`ADDR_W{1'b0}};
      serial_out_pin_out <= 1'b0;
      serial_out_pin_oe_n <= 1'b1;
      serial_inout_pin_out <= 1'b0;
      serial_inout_pin_oe_n <= 1'b1;
    end else begin
      go_prog <= 1'b0;
      go_erase <= 1'b0;
      set_wul <= 1'b0;
      if (cs_f) begin
        lstate <= L_CMD;
        bitn <= 5'h00;
        serial_out_pin_oe_n <= 1'b1;
        serial_inout_pin_oe_n <= 1'b1;
        if (cs_rise && lstate == L_PROG && bitn == 5'h00 && have_byte) begin
          go_prog <= 1'b1;
        end
        if (cs_rise && lstate == L_ERASE) begin
          go_erase <= 1'b1;
        end
        if (cs_rise && lstate == L_CMDEND) begin
          set_wul <= 1'b1;
        end
      end else if (sclk_rise) begin
        case (lstate)
          L_CMD: begin
            cmd <= next_cmd;
            bitn <= bitn + 5'h01;
            if (bitn == 5'h07) begin
              bitn <= 5'h00;
              dual_in <= (next_cmd == `OP_DUAL_IO);
              dual_out <= (next_cmd == `OP_DUAL_OUT) | (next_cmd == `OP_DUAL_IO);
              dummy <= (next_cmd == `OP_READ) ? 5'h00 :
                (next_cmd == `OP_DUAL_IO) ? `DUMMY_DUAL_IO :
                (next_cmd == `OP_DUAL_OUT) ? `DUMMY_DUAL_OUT : `DUMMY_FAST;
              have_byte <= 1'b0;
              if (next_cmd == `OP_PAGE_WRITE && write_unlock_latch && !busy) begin
                mask <= {256{1'b0}};
              end
              if (is_read) begin
                lstate <= busy ? L_IGN : L_ADDR;
              end else if (is_write) begin
                lstate <= (write_unlock_latch && !busy) ? L_ADDR : L_IGN;
              end else if (next_cmd == `OP_WRITE_UNLOCK) begin
                lstate <= L_CMDEND;
              end else begin
                lstate <= L_IGN;
              end
            end
          end
          L_ADDR: begin
            addr <= next_addr;
            bitn <= bitn + (dual_in ? 5'h02 : 5'h01);
            if (bitn == (dual_in ? `ADDR_LAST_DUAL : `ADDR_LAST_SINGLE)) begin
              bitn <= 5'h00;
              mem_addr <= next_addr;
              col <= next_addr[7:0];
              if (cmd == `OP_PAGE_WRITE) begin
                lstate <= L_PROG;
              end else if (cmd == `OP_SECTOR_CLEAR || cmd == `OP_BLOCK_CLEAR) begin
                lstate <= L_ERASE;
              end else begin
                lstate <= (dummy == 5'h00) ? L_DATA : L_DUMMY;
              end
            end
          end
          L_DUMMY: begin
            bitn <= bitn + 5'h01;
            if (bitn == dummy - 5'h01) begin
              bitn <= 5'h00;
              lstate <= L_DATA;
            end
          end
          L_PROG: begin
            pbyte <= {pbyte[6:0], dio_f};
            bitn <= (bitn == 5'h07) ? 5'h00 : bitn + 5'h01;
            if (bitn == 5'h07) begin
              mask[col] <= 1'b1;
              col <= col + 8'h01;
              have_byte <= 1'b1;
            end
          end
          L_ERASE, L_CMDEND: begin
            lstate <= L_IGN;
          end
          default: begin
            lstate <= lstate;
          end
        endcase
      end else if (sclk_fall && lstate == L_DATA) begin
        serial_out_pin_out <= out_byte[7];
        serial_out_pin_oe_n <= 1'b0;
        if (dual_out) begin
          serial_inout_pin_out <= out_byte[6];
          serial_inout_pin_oe_n <= 1'b0;
          shreg <= {out_byte[5:0], 2'b00};
          bitn <= (bitn == 5'h03) ? 5'h00 : bitn + 5'h01;
        end else begin
          shreg <= {out_byte[6:0], 1'b0};
          bitn <= (bitn == 5'h07) ? 5'h00 : bitn + 5'h01;
        end
        if (bitn == 5'h00) begin
          mem_addr <= mem_addr + 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Self-timed program and erase cycles
  // ==========================================================
  reg [1:0] op;
  reg [7:0] idx;
  reg [31:0] tmr;
  reg [`ADDR_W-9:0] page;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [`ADDR_W+7:0] fifo_out_data;
  wire drain_push = (op == O_DRAIN) & mask[idx];
  wire fifo_take = ~prog_valid | prog_ready;

  prog_fifo #(
    .WIDTH(`ADDR_W + 8),
    .DEPTH(FIFO_DEPTH),
    .AW(3)
  ) u_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(drain_push),
    .in_data({page, idx, page_buf[idx]}),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out_data),
    .out_ready(fifo_take)
  );

  // Array ANDs prog_data into the old byte, so bits only go from 1 to 0
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prog_valid <= 1'b0;
      prog_addr <= {`ADDR_W{1'b0}};
      prog_data <= 8'h00;
    end else if (fifo_take) begin
      prog_valid <= fifo_out_valid;
      prog_addr <= fifo_out_data[`ADDR_W+7:8];
      prog_data <= fifo_out_data[7:0];
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      op <= O_IDLE;
      idx <= 8'h00;
      tmr <= 32'h0000_0000;
      page <= {(`ADDR_W-8){1'b0}};
      write_unlock_latch <= 1'b0;
      operation_pending_flag <= 1'b0;
      erase_req <= 1'b0;
      erase_block <= 1'b0;
      erase_addr <= {`ADDR_W{1'b0}};
    end else begin
      erase_req <= 1'b0;
      case (op)
        O_IDLE: begin
          if (set_wul && !busy) begin
            write_unlock_latch <= 1'b1;
          end
          if (go_prog && !is_protected(protect_level_bits, addr[`BLOCK_MSB:`BLOCK_LSB])) begin
            op <= O_DRAIN;
            idx <= 8'h00;
            page <= addr[`ADDR_W-1:8];
            tmr <= PROG_CYCLES;
            operation_pending_flag <= 1'b1;
            write_unlock_latch <= 1'b0;
          end
          if (go_erase && !is_protected(protect_level_bits, addr[`BLOCK_MSB:`BLOCK_LSB])) begin
            op <= O_TIME;
            erase_req <= 1'b1;
            erase_block <= (cmd == `OP_BLOCK_CLEAR);
            erase_addr <= addr;
            tmr <= (cmd == `OP_BLOCK_CLEAR) ? BLOCK_CYCLES : SECTOR_CYCLES;
            operation_pending_flag <= 1'b1;
            write_unlock_latch <= 1'b0;
          end
        end
        O_DRAIN: begin
          if (tmr != 32'h0000_0000) begin
            tmr <= tmr - 32'h0000_0001;
          end
          if (!mask[idx] || fifo_in_ready) begin
            idx <= idx + 8'h01;
            if (idx == 8'hFF) begin
              op <= O_TIME;
            end
          end
        end
        O_TIME: begin
          if (tmr != 32'h0000_0000) begin
            tmr <= tmr - 32'h0000_0001;
          end else if (!fifo_out_valid && !prog_valid) begin
            op <= O_IDLE;
            operation_pending_flag <= 1'b0;
          end
        end
        default: begin
          op <= O_IDLE;
        end
      endcase
    end
  end
endmodule // serial_flash_seq

// ==== serial_flash_seq_assertions.sv ====
`timescale 1ns/1ps
`include "flash_defs.vh"
module serial_flash_seq_assertions (
  input wire core_clk,
  input wire rst,
  input wire chip_select_n,
  input wire serial_clk,
  input wire serial_out_pin_out,
  input wire serial_out_pin_oe_n,
  input wire serial_inout_pin_oe_n,
  input wire [2:0] protect_level_bits,
  input wire status_write_busy,
  input wire write_unlock_latch,
  input wire operation_pending_flag,
  input wire [`ADDR_W-1:0] mem_addr,
  input wire prog_valid,
  input wire [`ADDR_W-1:0] prog_addr,
  input wire erase_req,
  input wire [`ADDR_W-1:0] erase_addr
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ==========================================
  // Frame that has seen a busy device at every cycle so far
  reg quiet;
  wire busy = operation_pending_flag | status_write_busy;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      quiet <= 1'b1;
    end else begin
      quiet <= chip_select_n | (quiet & busy);
    end
  end
  function automatic bit prot(input [2:0] l, input [3:0] b);
    prot = (l >= 3'h5) || (l != 3'h0 && b >= 5'h10 - (5'h1 << (l - 3'h1)));
  endfunction
  // ==========================================
  // Properties
  property p_idle_quiet;
    chip_select_n [*8] |-> serial_out_pin_oe_n && serial_inout_pin_oe_n;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("pin driven while deselected");
  property p_out_on_fall;
    !serial_out_pin_oe_n && $past(!serial_out_pin_oe_n) && $changed(serial_out_pin_out)
      |-> !$past(serial_clk, 5);
  endproperty
  a_out_on_fall: assert property (p_out_on_fall) else $error("output moved off low phase");
  property p_addr_step;
    !serial_out_pin_oe_n && $past(!serial_out_pin_oe_n) && $changed(mem_addr)
      |-> mem_addr - $past(mem_addr) == 20'h00001;
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("read address not stepped by one");
  property p_busy_quiet;
    !chip_select_n && quiet && busy |-> serial_out_pin_oe_n;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("read answered while busy");
  property p_dual_pair;
    !serial_inout_pin_oe_n |-> !serial_out_pin_oe_n;
  endproperty
  a_dual_pair: assert property (p_dual_pair) else $error("dual output on one pin only");
  property p_latch_done;
    $fell(operation_pending_flag) |-> !write_unlock_latch;
  endproperty
  a_latch_done: assert property (p_latch_done) else $error("latch set at cycle end");
  property p_erase_latch;
    erase_req |-> write_unlock_latch || $past(write_unlock_latch) || $past(write_unlock_latch, 2);
  endproperty
  a_erase_latch: assert property (p_erase_latch) else $error("erase without unlock");
  property p_erase_flag;
    erase_req |-> ##[0:2] operation_pending_flag [*8];
  endproperty
  a_erase_flag: assert property (p_erase_flag) else $error("erase cycle not pending");
  property p_no_prot;
    prog_valid || erase_req
      |-> !prot(protect_level_bits, prog_valid ? prog_addr[19:16] : erase_addr[19:16]);
  endproperty
  a_no_prot: assert property (p_no_prot) else $error("protected area changed");
  property p_prog_flag;
    prog_valid |-> operation_pending_flag;
  endproperty
  a_prog_flag: assert property (p_prog_flag) else $error("program byte outside cycle");
  c_erase: cover property (erase_req);
  c_dual: cover property (!serial_inout_pin_oe_n);
  c_stall: cover property (prog_valid && operation_pending_flag [*8]);
endmodule // serial_flash_seq_assertions

// ==== spi_host.sv ====
`timescale 1ns/1ps
module spi_host #(
  parameter H = 40
) (
  output logic chip_select_n,
  output logic serial_clk,
  output logic dio_en,
  output logic dio_val,
  output logic do_en,
  output logic do_val,
  input wire logic dio_w,
  input wire logic do_w
);
  initial begin
    chip_select_n = 1'b1;
    serial_clk = 1'b0;
    dio_en = 1'b0;
    dio_val = 1'b0;
    do_en = 1'b0;
    do_val = 1'b0;
  end
  // ==========================================
  // One link clock; pins are sampled late, just before the fall, to absorb sync delay
  task automatic pulse(output logic i1, output logic i0);
    #H;
    serial_clk = 1'b1;
    #H;
    i1 = do_w;
    i0 = dio_w;
    serial_clk = 1'b0;
  endtask
  task automatic send(input logic [23:0] v, input int n, input bit dual);
    logic a, b;
    for (int k = 0; k < n; k++) begin
      dio_en = 1'b1;
      do_en = dual;
      do_val = v[23];
      dio_val = dual ? v[22] : v[23];
      v = dual ? v << 2 : v << 1;
      pulse(a, b);
    end
  endtask
  // Both pins released before the first output fall; also serves as dummy clocks
  task automatic recv(input bit dual, output logic [7:0] r);
    logic a, b;
    dio_en = 1'b0;
    do_en = 1'b0;
    r = 8'h00;
    for (int k = 0; k < (dual ? 4 : 8); k++) begin
      pulse(a, b);
      r = dual ? {r[5:0], a, b} : {r[6:0], a};
    end
  endtask
  task automatic begin_frame();
    chip_select_n = 1'b0;
    #H;
  endtask
  task automatic end_frame();
    #(H / 2);
    chip_select_n = 1'b1;
    dio_en = 1'b0;
    do_en = 1'b0;
    #(2 * H);
  endtask
endmodule // spi_host

// ==== tb.sv ====
`timescale 1ns/1ps
`include "flash_defs.vh"
module tb;
  reg core_clk, rst, tg, prog_ready, stall, status_write_busy;
  reg [2:0] protect_level_bits;
  wire chip_select_n, serial_clk, dio_en, dio_val, do_en, do_val, dio_w, do_w;
  wire serial_inout_pin_out, serial_inout_pin_oe_n, serial_out_pin_out, serial_out_pin_oe_n;
  wire write_unlock_latch, operation_pending_flag, prog_valid, erase_req, erase_block;
  wire [`ADDR_W-1:0] mem_addr, prog_addr, erase_addr;
  wire [7:0] prog_data, mem_rdata;
  integer n_mismatch, tests_run, seed, n_erase, k;
  logic [7:0] mem [int];
  logic [7:0] expq [int];
  logic [7:0] ops [4] = '{`OP_READ, `OP_FAST_READ, `OP_DUAL_OUT, `OP_DUAL_IO};
  reg last_blk;
  reg [`ADDR_W-1:0] last_ea;
  assign dio_w = !serial_inout_pin_oe_n ? serial_inout_pin_out : (dio_en ? dio_val : tg);
  assign do_w = !serial_out_pin_oe_n ? serial_out_pin_out : (do_en ? do_val : tg);
  function automatic logic [7:0] mdl(input logic [19:0] x);
    mdl = mem.exists(x) ? mem[x] : x[7:0] ^ x[19:12] ^ 8'h5A;
  endfunction
  assign mem_rdata = mdl(mem_addr);
  serial_flash_seq #(.PROG_CYCLES(50), .SECTOR_CYCLES(60), .BLOCK_CYCLES(80), .FIFO_DEPTH(8))
    serial_flash_seq_inst (.core_clk(core_clk), .rst(rst), .chip_select_n(chip_select_n),
    .serial_clk(serial_clk), .serial_inout_pin_in(dio_w),
    .serial_inout_pin_out(serial_inout_pin_out), .serial_inout_pin_oe_n(serial_inout_pin_oe_n),
    .serial_out_pin_in(do_w), .serial_out_pin_out(serial_out_pin_out),
    .serial_out_pin_oe_n(serial_out_pin_oe_n), .protect_level_bits(protect_level_bits),
    .status_write_busy(status_write_busy), .write_unlock_latch(write_unlock_latch),
    .operation_pending_flag(operation_pending_flag), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .prog_valid(prog_valid), .prog_addr(prog_addr), .prog_data(prog_data),
    .prog_ready(prog_ready), .erase_req(erase_req), .erase_block(erase_block),
    .erase_addr(erase_addr));
  spi_host host_inst (.chip_select_n(chip_select_n), .serial_clk(serial_clk), .dio_en(dio_en),
    .dio_val(dio_val), .do_en(do_en), .do_val(do_val), .dio_w(dio_w), .do_w(do_w));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================
  // Array model: program port and erase requests
  always @(posedge core_clk) begin
    tg <= ~tg;
    prog_ready <= !stall && ($random(seed) % 4 != 0);
    if (prog_valid && prog_ready) begin
      if (!expq.first(k)) k = -1;
      check(32'(prog_addr), k);
      check(32'(prog_data), 32'(expq[k]));
      expq.delete(k);
      mem[prog_addr] = mdl(prog_addr) & prog_data;
    end
    if (erase_req) begin
      n_erase <= n_erase + 1;
      last_blk <= erase_block;
      last_ea <= erase_addr;
    end
  end
  task automatic setin(input [2:0] l, input s);
    @(posedge core_clk);
    protect_level_bits <= l;
    status_write_busy <= s;
    #3;
  endtask
  task automatic op8(input [7:0] o);
    host_inst.send({o, 16'h0}, 8, 1'b0);
  endtask
  task automatic unlock();
    host_inst.begin_frame();
    op8(`OP_WRITE_UNLOCK);
    host_inst.end_frame();
    check(write_unlock_latch, 1'b1);
  endtask
  task automatic rd(input [7:0] o, input [19:0] a, input int n, input bit ok);
    logic [7:0] r;
    host_inst.begin_frame();
    op8(o);
    host_inst.send({4'h0, a}, o == `OP_DUAL_IO ? 12 : 24, o == `OP_DUAL_IO);
    if (o != `OP_READ) host_inst.recv(o == `OP_DUAL_IO, r);
    for (int j = 0; j < n; j++) begin
      host_inst.recv(o == `OP_DUAL_OUT || o == `OP_DUAL_IO, r);
      check(ok ? r : serial_out_pin_oe_n, ok ? mdl(a + j) : 1'b1);
    end
    host_inst.end_frame();
  endtask
  task automatic wr(input [7:0] o, input [19:0] a, input int n, input int extra, input bit ok);
    integer ne;
    logic [7:0] d, m;
    ne = n_erase;
    m = (o == `OP_BLOCK_CLEAR) ? 8'hF0 : 8'hFF;
    host_inst.begin_frame();
    op8(o);
    host_inst.send({4'h0, a}, 24, 1'b0);
    for (int j = 0; j < n; j++) begin
      d = $random(seed);
      if (ok) expq[{a[19:8], a[7:0] + 8'(j)}] = d;
      op8(d);
    end
    if (extra > 0) host_inst.send(24'h0, extra, 1'b0);
    host_inst.end_frame();
    check(n_erase, ne + (ok && n == 0));
    check(operation_pending_flag, ok);
    if (ok) check(write_unlock_latch, 1'b0);
    if (ok && n == 0) check({last_blk, last_ea[19:12] & m}, {m == 8'hF0, a[19:12] & m});
  endtask
  task automatic idle();
    int c;
    c = 0;
    while (operation_pending_flag !== 1'b0 && c < 5000) begin
      @(posedge core_clk);
      c++;
    end
    check(c < 5000, 1'b1);
    check(expq.size(), 0);
    #3;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #900000;
    n_mismatch = n_mismatch + 1;
    conclude();
  end
  initial begin
    {rst, tg, prog_ready, stall, status_write_busy, protect_level_bits} = 8'h80;
    {n_mismatch, tests_run, n_erase, seed} = {32'h0, 32'h0, 32'h0, 32'h7a5fcda6};
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    repeat (10) @(posedge core_clk);
    #3;
    foreach (ops[i]) rd(ops[i], 20'hFFFFE, 3, 1'b1);
    $display("reads with wrap done");
    unlock();
    wr(`OP_PAGE_WRITE, 20'h123FE, 3, 0, 1'b1);
    idle();
    rd(`OP_READ, 20'h12300, 2, 1'b1);
    rd(`OP_DUAL_IO, 20'h123FD, 3, 1'b1);
    $display("page write wrap done");
    unlock();
    stall = 1'b1;
    wr(`OP_PAGE_WRITE, 20'h45680, 257, 0, 1'b1);
    rd(`OP_READ, 20'h45680, 1, 1'b0);
    rd(`OP_FAST_READ, 20'h45680, 1, 1'b0);
    stall = 1'b0;
    idle();
    setin(3'h0, 1'b1);
    rd(`OP_READ, 20'h00000, 1, 1'b0);
    setin(3'h0, 1'b0);
    $display("busy rejection done");
    wr(`OP_PAGE_WRITE, 20'h00010, 2, 0, 1'b0);
    wr(`OP_SECTOR_CLEAR, 20'h01000, 0, 0, 1'b0);
    unlock();
    wr(`OP_PAGE_WRITE, 20'h00010, 2, 3, 1'b0);
    unlock();
    wr(`OP_SECTOR_CLEAR, 20'h01000, 0, 1, 1'b0);
    unlock();
    setin(3'h5, 1'b0);
    wr(`OP_BLOCK_CLEAR, 20'h20000, 0, 0, 1'b0);
    wr(`OP_PAGE_WRITE, 20'h20000, 1, 0, 1'b0);
    setin(3'h1, 1'b0);
    wr(`OP_SECTOR_CLEAR, 20'hF1000, 0, 0, 1'b0);
    check(write_unlock_latch, 1'b1);
    $display("refused writes done");
    wr(`OP_SECTOR_CLEAR, 20'h3A123, 0, 0, 1'b1);
    idle();
    unlock();
    wr(`OP_BLOCK_CLEAR, 20'h7FFFF, 0, 0, 1'b1);
    idle();
    $display("erases done");
    conclude();
  end
endmodule // tb
bind serial_flash_seq serial_flash_seq_assertions serial_flash_seq_assertions_inst (
  .core_clk(core_clk), .rst(rst), .chip_select_n(chip_select_n), .serial_clk(serial_clk),
  .serial_out_pin_out(serial_out_pin_out), .serial_out_pin_oe_n(serial_out_pin_oe_n),
  .serial_inout_pin_oe_n(serial_inout_pin_oe_n), .protect_level_bits(protect_level_bits),
  .status_write_busy(status_write_busy), .write_unlock_latch(write_unlock_latch),
  .operation_pending_flag(operation_pending_flag), .mem_addr(mem_addr),
  .prog_valid(prog_valid), .prog_addr(prog_addr), .erase_req(erase_req),
  .erase_addr(erase_addr));
